// >>> bench/config_prom_output_control_tb.sv
// Purpose: Self-checking bench for the configuration memory output control
// Assumes: Four-bit address, so the terminal count is 15
// Notes: Integer model tracks address and output enables
`timescale 1ns/1ps
module config_prom_output_control_tb;
    import cfg_loader_pkg::*;
    localparam int TC = 15;
    logic hclk, hresetn, hsel, hwrite, hready, hresp, ce_n, oe_reset_n, config_pulse_n, busy;
    logic config_clk, data_oe, clock_output, clock_output_oe, cascade_select_out_n;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [3:0] mem_addr;
    logic [2:0] cclk_pipe;
    logic [7:0] mem_data, data_out;
    int mismatches, checks, cycles, m_addr, sb, held, par, rev_on, bsy_h, ea, st, n, r;

    config_prom_output_control #(.ADDR_W(4), .DATA_W(8)) u_dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .ce_n(ce_n), .oe_reset_n(oe_reset_n), .config_pulse_n(config_pulse_n),
        .busy(busy), .config_clk(config_clk), .mem_addr(mem_addr), .mem_data(mem_data),
        .data_out(data_out), .data_oe(data_oe), .clock_output(clock_output),
        .clock_output_oe(clock_output_oe), .cascade_select_out_n(cascade_select_out_n));
    fpga_port_model u_fpga (.hclk(hclk), .mem_addr(mem_addr), .mem_data(mem_data),
        .config_clk(config_clk));

    // ----------------------------------------
    // Checking and model
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    function automatic int act();
        if (sb || held) return 0;
        if (par && bsy_h && busy === 1'b1) return 1;
        return m_addr < TC && (!par || m_addr < ea);
    endfunction : act

    task automatic mclk();
        if (!sb && !held && !(par && bsy_h && busy) && m_addr < TC && (!par || m_addr < ea))
            m_addr++;
    endtask : mclk

    task automatic run(input int k);
        u_fpga.pulse(k);
        repeat (k) mclk();
    endtask : run

    // Six edges covers the three-edge pin latency with margin
    task automatic cmp_all();
        repeat (6) @(posedge hclk);
        chk("addr", m_addr, mem_addr);
        chk("data_oe", act(), data_oe);
        chk("clk_oe", par ? act() : 0, clock_output_oe);
        chk("cascade", sb || held || m_addr < TC, cascade_select_out_n);
        if (act()) chk("data", {4'(m_addr), ~4'(m_addr)}, data_out);
    endtask : cmp_all

    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", 0, hresp);
    endtask : ahb

    task automatic setc(input logic [31:0] v);
        ahb(1'b1, CTRL_OFS, v);
        par = v[CTRL_PAR_VARIANT];
        rev_on = par && v[CTRL_REV_EN];
        bsy_h = par && v[CTRL_PAR_OUT] && !v[CTRL_DECOMP];
        ea = rev_on ? 7 : 99;
        st = rev_on ? 4 : 0;
    endtask : setc

    task automatic pins(input logic ce, input logic oe, input logic cf, input logic b);
        @(posedge hclk);
        ce_n <= ce;
        oe_reset_n <= oe;
        config_pulse_n <= cf;
        busy <= b;
        sb = ce;
        held = !oe;
        if (sb || held || (par && !cf)) m_addr = st;
    endtask : pins

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // Clock, timeout, sequence
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // Clock output trails the pin by two sync stages and its own register
    always @(posedge hclk) begin
        cclk_pipe <= {cclk_pipe[1:0], config_clk};
        if (hresetn && clock_output_oe) begin
            chk("clock_output", cclk_pipe[2], clock_output);
        end
    end

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        {hresetn, hsel, hwrite, busy, haddr, hwdata, htrans} = '0;
        {ce_n, oe_reset_n, config_pulse_n} = 3'h7;
        {mismatches, checks, cycles, m_addr, held, par, rev_on, bsy_h, st} = '0;
        sb = 1;
        ea = 99;
        r = $urandom(60);
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        cmp_all();
        ahb(1'b0, CTRL_OFS, 32'h0000_0000);
        chk("ctrl", CTRL_RESET, rd);
        ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
        ahb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        setc(32'h0000_0000);
        pins(1'b0, 1'b1, 1'b1, 1'b0);
        n = 3 + $urandom % 4;
        run(n);
        cmp_all();
        run(14);
        cmp_all();
        pins(1'b0, 1'b0, 1'b1, 1'b0);
        cmp_all();
        pins(1'b1, 1'b1, 1'b1, 1'b0);
        run(2);
        cmp_all();
        ahb(1'b0, STAT_OFS, 32'h0000_0000);
        chk("standby", 1, rd[STAT_STANDBY]);
        setc(32'h0000_0005);
        pins(1'b0, 1'b1, 1'b1, 1'b0);
        run(n);
        cmp_all();
        pins(1'b0, 1'b1, 1'b0, 1'b0);
        cmp_all();
        pins(1'b0, 1'b1, 1'b1, 1'b1);
        run(2);
        cmp_all();
        setc(32'h0000_000D);
        run(2);
        cmp_all();
        r = $urandom % REV_COUNT;
        ahb(1'b1, REV_OFS + 8'(4 * r), 32'h0007_0004);
        setc(32'h0000_0007 | (32'(r) << CTRL_REV_SEL_LSB));
        pins(1'b0, 1'b1, 1'b0, 1'b0);
        cmp_all();
        pins(1'b0, 1'b1, 1'b1, 1'b0);
        run(5);
        cmp_all();
        pins(1'b0, 1'b0, 1'b1, 1'b0);
        cmp_all();
        complete_run();
    end
endmodule : config_prom_output_control_tb

// >>> bench/fpga_port_model.sv
// Purpose: Far-side model: configuration clock source and memory array
// Assumes: Memory word is a fixed function of the address
// Notes: Clock stands still between frames
`timescale 1ns/1ps
module fpga_port_model (
    input wire logic hclk,
    input wire logic [3:0] mem_addr,
    output logic [7:0] mem_data,
    output logic config_clk
);
    // ----------------------------------------
    // Memory array
    // ----------------------------------------
    // Address and its inverse, so a stuck or swapped address bit shows in the word
    always_comb mem_data = {mem_addr, ~mem_addr};

    // ----------------------------------------
    // Configuration clock
    // ----------------------------------------
    initial config_clk = 1'b0;

    // Each phase lasts 4 cycles, above the 3 the sampler needs
    task automatic pulse(input int n);
        repeat (n) begin
            repeat (4) @(posedge hclk);
            config_clk <= 1'b1;
            repeat (4) @(posedge hclk);
            config_clk <= 1'b0;
        end
        repeat (4) @(posedge hclk);
    endtask : pulse
endmodule : fpga_port_model

// >>> hdl/cfg_loader_pkg.sv
// Purpose: Shared constants for the configuration memory output control block
// Assumes: 32-bit AHB-Lite register access, word aligned
// Notes: Offsets are byte addresses
package cfg_loader_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] REV_OFS = 8'h10;
    localparam int REV_COUNT = 4;

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int CTRL_PAR_VARIANT = 0;
    localparam int CTRL_REV_EN = 1;
    localparam int CTRL_PAR_OUT = 2;
    localparam int CTRL_DECOMP = 3;
    localparam int CTRL_REV_SEL_LSB = 4;
    localparam int REV_SEL_W = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // ----------------------------------------
    // Revision table fields: start low half, end high half
    // ----------------------------------------
    localparam int REV_START_LSB = 0;
    localparam int REV_END_LSB = 16;
    localparam logic [31:0] REV_RESET = 32'h0000_0000;

    // ----------------------------------------
    // Status fields
    // ----------------------------------------
    localparam int STAT_ADDR_LSB = 0;
    localparam int STAT_CASCADE = 16;
    localparam int STAT_DATA_OE = 17;
    localparam int STAT_STANDBY = 18;
    localparam int STAT_HELD = 19;

    // ----------------------------------------
    // AHB encodings
    // ----------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ = 2'b11;

endpackage : cfg_loader_pkg

// >>> hdl/config_prom_output_control.sv
// Purpose: Address counter and output control of a configuration memory
// Assumes: Pins are asynchronous to hclk; memory word for mem_addr arrives on mem_data
// Notes: Configuration clock is sampled, so it must be well below hclk/4
//
// Functional notes
// - Select high means standby: counter reset, cascade high, other outputs floated.
// - Serial variant counts to last address, then holds, floats data, cascade low.
// - Terminal count is the highest address of the array.
// - Parallel variant counts below last and end address; stops with outputs floated.
// - With revisioning, the end address is the selected revision's last address.
// - Busy honoured only for parallel uncompressed output; holds address, outputs active.
// - With revisioning, pulse resets to bank start; held reset floats data and clock.
// - Without revisioning every address reset returns the counter to zero.
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module config_prom_output_control
    import cfg_loader_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic ce_n,
    input wire logic oe_reset_n,
    input wire logic config_pulse_n,
    input wire logic busy,
    input wire logic config_clk,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_data,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    output logic clock_output,
    output logic clock_output_oe,
    output logic cascade_select_out_n
);
    localparam logic [ADDR_W-1:0] LAST_ADDRESS_COUNT = '1;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [4:0] pins_s;
    logic ce_n_s, oe_s, cf_n_s, busy_s, cclk_s;

    pin_sync #(.WIDTH(5), .RESET_VAL(5'h07)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in({config_clk, busy, config_pulse_n, oe_reset_n, ce_n}),
        .pin_sync_out(pins_s)
    );
    assign {cclk_s, busy_s, cf_n_s, oe_s, ce_n_s} = pins_s;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] rev_q [REV_COUNT];
    logic [31:0] rev_d [REV_COUNT];
    logic [31:0] hrdata_q, hrdata_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_ofs_q, wr_ofs_d;
    logic [31:0] status;
    logic [31:0] rd_val;
    logic take;

    assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

    // Byte offset of one revision table entry, shared by read and write decode
    function automatic logic [7:0] rev_ofs(input int idx);
        return REV_OFS + 8'(4 * idx);
    endfunction : rev_ofs

    always_comb begin
        rd_val = 32'h0000_0000;
        if (haddr[7:0] == CTRL_OFS) begin
            rd_val = ctrl_q;
        end else if (haddr[7:0] == STAT_OFS) begin
            rd_val = status;
        end
        for (int i = 0; i < REV_COUNT; i++) begin
            if (haddr[7:0] == rev_ofs(i)) begin
                rd_val = rev_q[i];
            end
        end
    end

    always_comb begin
        ctrl_d = ctrl_q;
        rev_d = rev_q;
        hrdata_d = hrdata_q;
        wr_pend_d = take && hwrite;
        wr_ofs_d = take ? haddr[7:0] : wr_ofs_q;
        if (take && !hwrite) begin
            hrdata_d = rd_val;
        end
        if (wr_pend_q) begin
            if (wr_ofs_q == CTRL_OFS) begin
                ctrl_d = hwdata;
            end
            for (int i = 0; i < REV_COUNT; i++) begin
                if (wr_ofs_q == rev_ofs(i)) begin
                    rev_d[i] = hwdata;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RESET;
            for (int i = 0; i < REV_COUNT; i++) begin
                rev_q[i] <= REV_RESET;
            end
            hrdata_q <= 32'h0000_0000;
            wr_pend_q <= 1'b0;
            wr_ofs_q <= 8'h00;
        end else begin
            ctrl_q <= ctrl_d;
            rev_q <= rev_d;
            hrdata_q <= hrdata_d;
            wr_pend_q <= wr_pend_d;
            wr_ofs_q <= wr_ofs_d;
        end
    end

    // Zero wait states; every access answers OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // ----------------------------------------
    // Counter control
    // ----------------------------------------
    logic par, rev_en, busy_honor;
    logic [REV_SEL_W-1:0] rev_sel;
    logic [ADDR_W-1:0] bank_start, end_addr, reset_base;
    logic held_reset, pulse_reset, cclk_prev_q, cclk_rise;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] data_q, data_d;
    logic data_oe_q, data_oe_d, clk_q, clk_d, clk_oe_q, clk_oe_d, casc_q, casc_d;

    assign par = ctrl_q[CTRL_PAR_VARIANT];
    assign rev_en = par && ctrl_q[CTRL_REV_EN];
    assign busy_honor = par && ctrl_q[CTRL_PAR_OUT] && !ctrl_q[CTRL_DECOMP];
    assign rev_sel = ctrl_q[CTRL_REV_SEL_LSB +: REV_SEL_W];
    assign bank_start = rev_q[rev_sel][REV_START_LSB +: ADDR_W];
    assign end_addr = rev_en ? rev_q[rev_sel][REV_END_LSB +: ADDR_W] : LAST_ADDRESS_COUNT;
    assign reset_base = rev_en ? bank_start : '0;
    assign held_reset = ce_n_s || !oe_s;
    assign pulse_reset = par && !cf_n_s;
    assign cclk_rise = cclk_s && !cclk_prev_q;

    always_comb begin
        addr_d = addr_q;
        casc_d = 1'b1;
        data_oe_d = 1'b0;
        clk_oe_d = 1'b0;
        data_d = mem_data;
        clk_d = cclk_s;
        if (held_reset) begin
            addr_d = reset_base;
        end else if (pulse_reset) begin
            addr_d = reset_base;
            data_oe_d = 1'b1;
            clk_oe_d = 1'b1;
        end else if (par && busy_honor && busy_s) begin
            data_oe_d = 1'b1;
            clk_oe_d = 1'b1;
            data_d = data_q;
        end else if (addr_q == LAST_ADDRESS_COUNT) begin
            casc_d = 1'b0;
        end else if (par && addr_q == end_addr) begin
            casc_d = 1'b1;
        end else begin
            data_oe_d = 1'b1;
            clk_oe_d = par;
            if (cclk_rise) begin
                addr_d = addr_q + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= '0;
            data_q <= '0;
            data_oe_q <= 1'b0;
            clk_q <= 1'b0;
            clk_oe_q <= 1'b0;
            casc_q <= 1'b1;
            cclk_prev_q <= 1'b0;
        end else begin
            addr_q <= addr_d;
            data_q <= data_d;
            data_oe_q <= data_oe_d;
            clk_q <= clk_d;
            clk_oe_q <= clk_oe_d;
            casc_q <= casc_d;
            cclk_prev_q <= cclk_s;
        end
    end

    assign mem_addr = addr_q;
    assign data_out = data_q;
    assign data_oe = data_oe_q;
    assign clock_output = clk_q;
    assign clock_output_oe = clk_oe_q;
    assign cascade_select_out_n = casc_q;

    always_comb begin
        status = 32'h0000_0000;
        status[STAT_ADDR_LSB +: ADDR_W] = addr_q;
        status[STAT_CASCADE] = casc_q;
        status[STAT_DATA_OE] = data_oe_q;
        status[STAT_STANDBY] = ce_n_s;
        status[STAT_HELD] = held_reset;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_standby_outputs: assert property (@(posedge hclk) disable iff (!hresetn)
        ce_n_s |=> casc_q && !data_oe_q && !clk_oe_q && addr_q == $past(reset_base))
        else $error("standby did not reset counter or float outputs");

    a_serial_inc: assert property (@(posedge hclk) disable iff (!hresetn)
        (!par && !held_reset && cclk_rise && addr_q != LAST_ADDRESS_COUNT)
        |=> addr_q == $past(addr_q) + 1'b1 && data_oe_q)
        else $error("serial counter did not advance by one");

    a_serial_tc_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (!par && !held_reset && addr_q == LAST_ADDRESS_COUNT)
        |=> !casc_q && !data_oe_q && addr_q == LAST_ADDRESS_COUNT)
        else $error("serial terminal count not held");

    a_tc_value: assert property (@(posedge hclk) disable iff (!hresetn)
        (!held_reset && !pulse_reset && !(busy_honor && busy_s) && !casc_d)
        |-> addr_q == LAST_ADDRESS_COUNT)
        else $error("cascade handed over below terminal count");

    a_end_stop: assert property (@(posedge hclk) disable iff (!hresetn)
        (par && !held_reset && !pulse_reset && !(busy_honor && busy_s) && addr_q == end_addr
        && addr_q != LAST_ADDRESS_COUNT) [*2] |=> $stable(addr_q) && casc_q && !data_oe_q
        && !clk_oe_q)
        else $error("end address did not stop counting");

    a_busy_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (busy_honor && busy_s && !held_reset && !pulse_reset)
        |=> $stable(addr_q) && data_oe_q && clk_oe_q)
        else $error("busy did not hold address with outputs active");

    a_pulse_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        (rev_en && !held_reset && pulse_reset) |=> addr_q == $past(bank_start) && data_oe_q)
        else $error("pulse did not reset to bank start");

    a_held_float: assert property (@(posedge hclk) disable iff (!hresetn)
        held_reset |=> !data_oe_q && !clk_oe_q && casc_q)
        else $error("held reset did not float outputs");

    a_norev_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (!rev_en && (held_reset || pulse_reset)) |=> addr_q == '0)
        else $error("address reset without revisioning not zero");

endmodule : config_prom_output_control

// >>> hdl/pin_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pin inputs
// Assumes: Inputs are independent levels
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_sync_out = sync_q;
endmodule : pin_sync
